// ===== include/lbt_map.svh
// lin break timer: register offsets, field positions, reset values, timing
// assumes inclusion by the design module, the assertion checker and the testbench
`ifndef LBT_MAP_SVH
`define LBT_MAP_SVH
`define LBT_ADDR_W        32
`define LBT_BRK_OFFSET    32'hFFFF0790
`define LBT_STAT_OFFSET   32'hFFFF0794
`define LBT_CTRL_OFFSET   32'hFFFF0798
`define LBT_SYNC_OFFSET   32'hFFFF0788
`define LBT_CMP_RESET     12'h047
`define LBT_CNT_RESET     12'h000
`define LBT_STAT_BRK_BIT  0
`define LBT_STAT_ERR_BIT  4
`define LBT_STAT_SYNC_BIT 5
`define LBT_CTRL_EN_BIT   0
`define LBT_IRQ_LINE_BIT  7
`define LBT_LPO_KHZ       131
`define LBT_SYNC_KHZ      5000
`define LBT_REF_KHZ       100000
`define LBT_LPO_DIV       (`LBT_REF_KHZ / `LBT_LPO_KHZ)
`define LBT_SYNC_DIV      (`LBT_REF_KHZ / `LBT_SYNC_KHZ)
`endif

// ===== include/lbt_pkg.sv
// lin break timer types
// uses no macros from lbt_map.svh
package lbt_pkg;
  typedef logic [11:0] lbt_cnt_t;
  typedef logic [15:0] lbt_sync_t;
  typedef enum logic [3:0] {
    LBT_IDLE  = 4'b0001,
    LBT_LOW   = 4'b0010,
    LBT_ERR   = 4'b0100,
    LBT_SYNC  = 4'b1000
  } lbt_state_e;
endpackage

// ===== rtl/lbt_break_timer.sv
// lin break timer: break length, compare interrupt, break error, sync gate
// assumes a synchronous register port and an asynchronous lin bus pin
// Functional notes
// [RL1] reads of break location return running count
// [RL2] timer advances on every low-power oscillator tick
// [RL3] falling bus edge or read clears timer
// [RL4] writes load compare register, count untouched
// [RL5] equal count sets status bit 0, irq
// [RL6] timer does not stop at rising edge; count runs on past the rising edge until a fall or read clears it
// [RL7] overflow before rising edge sets status bit 4
// [RL8] compare register resets to 0x47
// [RL9] sync timing only after valid break
// [RL10] sync timer counts from internal 5MHz tick
// [RL11] break interrupt fires once per break
`timescale 1ns/100ps
`include "lbt_map.svh"
module lbt_break_timer (
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     resetn_in,
  // register port
  input  wire logic [`LBT_ADDR_W-1:0]   addr_in,
  input  wire logic [31:0]              wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  output logic      [31:0]              rdata_out,
  // lin bus
  input  wire logic                     lin_rx_in,
  // events
  output logic                          brk_irq_out,
  output logic                          err_irq_out,
  output logic                          sync_run_out
);
  import lbt_pkg::*;

  localparam int LPO_DIV  = `LBT_LPO_DIV;
  localparam int SYNC_DIV = `LBT_SYNC_DIV;

  logic [1:0]       lin_sync;
  logic             lin_q;
  logic             fall;
  logic             rise;
  logic [9:0]       lpo_div;
  logic             lpo_tick;
  logic [4:0]       syn_div;
  logic             syn_tick;
  lbt_cnt_t         count;
  lbt_cnt_t         cmp;
  lbt_sync_t        sync_cnt;
  logic             enable;
  logic             brk_flag;
  logic             err_flag;
  logic             brk_seen;
  lbt_state_e       state;
  logic             rd_brk;
  logic             wr_brk;
  logic             wr_stat;
  logic             wr_ctrl;
  logic             hit;
  logic             ovf;

  assign rd_brk  = rd_in && (addr_in == `LBT_BRK_OFFSET);
  assign wr_brk  = wr_in && (addr_in == `LBT_BRK_OFFSET);
  assign wr_stat = wr_in && (addr_in == `LBT_STAT_OFFSET);
  assign wr_ctrl = wr_in && (addr_in == `LBT_CTRL_OFFSET);

  // bus pin synchroniser and edges
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lin_sync <= 2'h3;
      lin_q    <= 1'b1;
    end else begin
      lin_sync <= {lin_sync[0], lin_rx_in};
      lin_q    <= lin_sync[1];
    end
  end
  assign fall = lin_q && !lin_sync[1];
  assign rise = !lin_q && lin_sync[1];

  // low-power oscillator tick
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lpo_div <= 10'h000;
    end else if (lpo_tick) begin
      lpo_div <= 10'h000;
    end else begin
      lpo_div <= lpo_div + 10'h001;
    end
  end
  assign lpo_tick = (lpo_div == 10'(LPO_DIV - 1)); // RL2

  // 5 MHz sync tick
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      syn_div <= 5'h00;
    end else if (syn_tick) begin
      syn_div <= 5'h00;
    end else begin
      syn_div <= syn_div + 5'h01;
    end
  end
  assign syn_tick = (syn_div == 5'(SYNC_DIV - 1)); // RL10

  assign ovf = lpo_tick && (count == 12'hFFF) && (state == LBT_LOW);
  assign hit = (count == cmp) && (state == LBT_LOW) && !brk_seen && enable;

  // break timer
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= `LBT_CNT_RESET;
    end else if (fall || rd_brk) begin
      count <= `LBT_CNT_RESET; // RL3
    end else if (lpo_tick) begin
      count <= count + 12'h001; // RL2 RL6
    end
  end

  // compare register and enable
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmp    <= `LBT_CMP_RESET; // RL8
      enable <= 1'b1;
    end else begin
      if (wr_brk) begin
        cmp <= wdata_in[11:0]; // RL4
      end
      if (wr_ctrl) begin
        enable <= wdata_in[`LBT_CTRL_EN_BIT];
      end
    end
  end

  // break state
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state    <= LBT_IDLE;
      brk_seen <= 1'b0;
    end else begin
      case (state)
        LBT_IDLE: begin
          if (fall && enable) begin
            state    <= LBT_LOW;
            brk_seen <= 1'b0;
          end
        end
        LBT_LOW: begin
          if (hit) begin
            brk_seen <= 1'b1; // RL11
          end
          if (rise) begin
            state <= (brk_seen || hit) ? LBT_SYNC : LBT_IDLE; // RL6 RL9
          end else if (ovf) begin
            state <= LBT_ERR; // RL7
          end
        end
        LBT_ERR: begin
          if (rise) begin
            state <= LBT_IDLE;
          end
        end
        LBT_SYNC: begin
          if (!enable) begin
            state <= LBT_IDLE;
          end
        end
        default: begin
          state <= LBT_IDLE;
        end
      endcase
    end
  end

  // sync timer, gated by a valid break
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_cnt <= 16'h0000;
    end else if (state != LBT_SYNC) begin
      sync_cnt <= 16'h0000; // RL9
    end else if (syn_tick) begin
      sync_cnt <= sync_cnt + 16'h0001; // RL10
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      brk_flag <= 1'b0;
      err_flag <= 1'b0;
    end else begin
      brk_flag <= hit ||
        (brk_flag && !(wr_stat && wdata_in[`LBT_STAT_BRK_BIT])); // RL5
      err_flag <= (ovf && enable) ||
        (err_flag && !(wr_stat && wdata_in[`LBT_STAT_ERR_BIT])); // RL7
    end
  end

  // event pulses and sync run level
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      brk_irq_out  <= 1'b0;
      err_irq_out  <= 1'b0;
      sync_run_out <= 1'b0;
    end else begin
      brk_irq_out  <= hit; // RL5 RL11
      err_irq_out  <= ovf && enable; // RL7
      sync_run_out <= (state == LBT_SYNC);
    end
  end

  // read data
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        `LBT_BRK_OFFSET:  rdata_out <= {20'h00000, count}; // RL1
        `LBT_STAT_OFFSET: rdata_out <= {26'h0,
                                        state == LBT_SYNC, err_flag,
                                        3'h0, brk_flag};
        `LBT_CTRL_OFFSET: rdata_out <= {31'h0, enable};
        `LBT_SYNC_OFFSET: rdata_out <= {16'h0000, sync_cnt};
        default:          rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end
endmodule

// ===== tb/lbt_break_timer_asserts.sv
// port checker for the lin break timer
// assumes lbt_map.svh on the include path, bound to the timer module
`timescale 1ns/100ps
`include "lbt_map.svh"
module lbt_break_timer_asserts (
  // watched ports
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic [31:0] addr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        lin_rx_in,
  input wire logic        brk_irq_out,
  input wire logic        err_irq_out,
  input wire logic        sync_run_out
);
  logic seen;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // break hit seen since last sync
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) seen <= 1'b0;
    else seen <= brk_irq_out | (seen & ~sync_run_out);
  end
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read slot");
  a_brk_upper: assert property ($past(rd_in && addr_in == `LBT_BRK_OFFSET)
    |-> rdata_out[31:12] == 20'h0) else $error("count upper bits");
  a_rd_clears: assert property (rd_in && addr_in == `LBT_BRK_OFFSET ##1
    rd_in && addr_in == `LBT_BRK_OFFSET |=> rdata_out[11:0] <= 12'h001)
    else $error("read did not clear count");
  a_brk_once: assert property (brk_irq_out |=> !brk_irq_out [*8])
    else $error("break pulse repeated");
  a_err_once: assert property (err_irq_out |=> !err_irq_out)
    else $error("error pulse repeated");
  a_brk_low: assert property (brk_irq_out |-> !$past(lin_rx_in, 4))
    else $error("break hit with bus high");
  a_sync_gate: assert property ($rose(sync_run_out) |-> seen)
    else $error("sync without break");
  a_sync_high: assert property ($rose(sync_run_out) |-> $past(lin_rx_in, 4))
    else $error("sync before bus rise");
endmodule
bind lbt_break_timer lbt_break_timer_asserts u_chk (.ref_clk_in, .resetn_in,
  .addr_in, .rd_in, .rdata_out, .lin_rx_in, .brk_irq_out, .err_irq_out,
  .sync_run_out);

// ===== tb/lbt_lin_master.sv
// lin master model: pulls the bus low for a set number of cycles
// assumes a pulled-up bus, high whenever released
`timescale 1ns/100ps
module lbt_lin_master (
  // clock and request
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [16:0] len_in,
  // bus
  output logic             lin_out
);
  logic [16:0] left = 17'h0;
  always @(posedge clk_in) begin
    if (go_in) left <= len_in;
    else if (left != 17'h0) left <= left - 17'h1;
  end
  assign lin_out = (left == 17'h0);
endmodule

// ===== tb/tb_lbt_break_timer.sv
// self-checking bench for the lin break timer
// assumes lbt_map.svh on the include path and the lin master model
`timescale 1ns/100ps
`include "lbt_map.svh"
module tb_lbt_break_timer;
  logic        ref_clk_in, resetn_in, wr_in, rd_in, go, lin_rx_in;
  logic        brk_irq_out, err_irq_out, sync_run_out;
  logic [31:0] addr_in, wdata_in, rdata_out, v, w;
  logic [16:0] len;
  int          num_errors, comparisons, cyc, hits, errs;
  lbt_break_timer DUT (.ref_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .lin_rx_in, .brk_irq_out, .err_irq_out,
    .sync_run_out);
  lbt_lin_master u_mst (.clk_in(ref_clk_in), .go_in(go), .len_in(len),
    .lin_out(lin_rx_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 75000) begin
      num_errors++;
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] s, e, input string n);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rd(input logic [31:0] a);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
    @(posedge ref_clk_in);
  endtask
  task automatic brk(input logic [16:0] n, input int wait_n);
    len <= n;
    go <= 1'b1;
    @(posedge ref_clk_in);
    go <= 1'b0;
    hits = 0;
    errs = 0;
    repeat (wait_n) begin
      @(posedge ref_clk_in);
      #1;
      if (brk_irq_out === 1'b1) hits++;
      if (err_irq_out === 1'b1) errs++;
    end
    @(posedge ref_clk_in);
  endtask
  task automatic t_break(input logic [16:0] n);
    brk(n, int'(n) + 20);
    chk(32'(hits), 32'h1, "break hits");
    chk(32'(errs), 32'h0, "error pulses");
    chk({31'h0, sync_run_out}, 32'h1, "sync run");
    rd(`LBT_STAT_OFFSET);
    chk(v & 32'h31, 32'h21, "status");
    wr(`LBT_STAT_OFFSET, 32'h11);
    rd(`LBT_STAT_OFFSET);
    chk(v & 32'h31, 32'h20, "status cleared");
    rd(`LBT_SYNC_OFFSET);
    chk(32'(v >= 32'h1 && v <= 32'h2), 32'h1, "sync count");
    wr(`LBT_CTRL_OFFSET, 32'h0);
    wr(`LBT_CTRL_OFFSET, 32'h1);
    chk({31'h0, sync_run_out}, 32'h0, "sync idle");
    $display("break test done");
  endtask
  task automatic t_count;
    wr(`LBT_BRK_OFFSET, 32'hFFF);
    brk(17'd3000, 2000);
    chk(32'(hits), 32'h0, "early hits");
    chk(32'(errs), 32'h0, "early errors");
    addr_in <= `LBT_BRK_OFFSET;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    #1 v = rdata_out;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 w = rdata_out;
    @(posedge ref_clk_in);
    chk(32'(v >= 2 && v <= 3), 32'h1, "count");
    chk(w, 32'h0, "count cleared");
    repeat (1100) @(posedge ref_clk_in);
    chk({31'h0, sync_run_out}, 32'h0, "no sync");
    rd(`LBT_STAT_OFFSET);
    chk(v & 32'h31, 32'h0, "no flags");
    $display("count test done");
  endtask
  initial begin
    {resetn_in, wr_in, rd_in, go, len, addr_in, wdata_in} = '0;
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(posedge ref_clk_in);
    rd(`LBT_BRK_OFFSET);
    chk(v, 32'h0, "count reset");
    rd(32'hFFFF07A0);
    chk(v, 32'h0, "unmapped");
    t_break(17'd54183);
    wr(`LBT_BRK_OFFSET, 32'h2);
    t_break(17'd3000);
    t_count;
    end_of_test;
  end
endmodule
